// file: src/ccd_divider.sv
/*
  Channel four cascaded clock divider with AHB-Lite register slave.
  // Function
  // [R1] Stage one stays low for low-count plus one input cycles.
  // [R2] Stage one stays high for high-count plus one input cycles.
  // [R3] Stage two stays low for its low-count plus one input cycles.
  // [R4] Stage two stays high for its high-count plus one input cycles.
  // [R5] Zero count gives a one-cycle phase; all counts reset to zero.
  // [R6] Two four-bit phase offset fields, stage two high nibble, reset zero.
  // [R7] Bypass bit 5 passes stage two input straight to its output.
  // [R8] Bypass bit 4 passes stage one input straight to its output.
  // [R9] Chip sync obeyed when ignore bit 3 clear, disregarded when set.
  // [R10] Bit 2 forces static output level; software must also set bit 3.
  // [R11] Stage two starts at the level of bit 1 after a sync.
  // [R12] Stage one starts at the level of bit 0 after a sync.
  // [R13] Duty correction active while correction bit 0 is zero.
  // [R14] Stage one output clocks stage two; division is the product.
  // [R15] Stage period is the sum of its low and high phases.
  Assumes the system clock is the channel input clock, sync is synchronous
  and active high, and the master issues single word transfers only.
  Limitations: phase offsets are stored and read back but not applied, and
  duty correction is only reported, since at one input cycle per clock the
  output already has whole-cycle edges to work with.
  A bypassed stage one toggles every clock, standing in for its raw input clock
  at half rate, and a bypassed stage two follows stage one; real hardware would route the clock itself.
  The force level is shown only while sync is asserted and ignored, so a
  stale force bit cannot freeze a running output on its own.
  Register map, one byte per aligned word, upper bits read zero:
    index stage_one_cycle_counts stage one cycle counts, stage_phase_offsets phase offsets,
    stage_two_cycle_counts stage two cycle counts, channel_bypass_sync_control bypass, sync and start control,
    channel_duty_correction duty correction, 0x1a3 read-only status of the stage levels.
  Bus timing: zero wait states; writes land at the end of the data phase
  and reads return the value in the data phase.
*/
`timescale 1ns/10ps
`default_nettype none
module ccd_divider
  import ccd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire ccd_pkg::ccd_ahb_req_t i_ahb,
  input wire logic i_sync,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_ch_out,
  output logic o_duty_correct_en
);
  import ccd_pkg::*;

  // Register file state
  logic [7:0] s1_counts_reg;
  logic [7:0] s1_counts_next;
  logic [7:0] phase_reg;
  logic [7:0] phase_next;
  logic [7:0] s2_counts_reg;
  logic [7:0] s2_counts_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] dcc_reg;
  logic [7:0] dcc_next;
  // Data phase bookkeeping of the bus slave
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [CCD_IDX_W-1:0] wr_idx_reg;
  logic [CCD_IDX_W-1:0] wr_idx_next;
  // Read data and ready, both registered
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hready_reg;
  logic hready_next;

  // Divider state
  ccd_stage_t s1_reg;
  ccd_stage_t s1_next;
  ccd_stage_t s2_reg;
  ccd_stage_t s2_next;
  logic rise1;
  ccd_sync_state_t st_reg;
  ccd_sync_state_t st_next;
  logic out_reg;
  logic out_next;
  logic dcc_en_reg;
  logic dcc_en_next;

  logic addr_ok;
  logic [CCD_IDX_W-1:0] a_idx;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;

  // One input tick of a divider stage; returns the next stage state
  function automatic ccd_stage_t stage_step(
    input ccd_stage_t cur,
    input logic [7:0] counts
  );
    ccd_stage_t nx;
    nx = cur;
    if (cur.cnt == CCD_CNT_ZERO) begin
      nx.lvl = ~cur.lvl;
      // Reload with the length of the phase just entered
      nx.cnt = nx.lvl ? counts[CCD_HIGH_MSB:CCD_HIGH_LSB] : counts[CCD_LOW_MSB:CCD_LOW_LSB];
    end else begin
      // Count down within the current phase
      nx.cnt = cur.cnt - 4'h1;
    end
    return nx;
  endfunction : stage_step

  // Load value for a stage at its start level
  function automatic ccd_stage_t stage_start(
    input logic start_hi,
    input logic [7:0] counts
  );
    ccd_stage_t nx;
    nx.lvl = start_hi;
    nx.cnt = start_hi ? counts[CCD_HIGH_MSB:CCD_HIGH_LSB] : counts[CCD_LOW_MSB:CCD_LOW_LSB];
    return nx;
  endfunction : stage_start

  // Address decode of the address phase
  // IDLE and BUSY transfers are ignored
  assign addr_ok = i_ahb.hsel && i_ahb.hready &&
                   (i_ahb.htrans == CCD_HTRANS_NONSEQ || i_ahb.htrans == CCD_HTRANS_SEQ);
  assign a_idx = i_ahb.haddr[CCD_IDX_LSB+CCD_IDX_W-1:CCD_IDX_LSB];
  assign status_byte = {5'h00, s2_reg.lvl, s1_reg.lvl, out_reg};

  // Read mux; unmapped indices read zero
  // Status shows live levels, so it is never forwarded
  always_comb begin
    case (a_idx)
      CCD_IDX_S1_COUNTS: rd_byte = s1_counts_reg;
      CCD_IDX_PHASE: rd_byte = phase_reg;
      CCD_IDX_S2_COUNTS: rd_byte = s2_counts_reg;
      CCD_IDX_CTRL: rd_byte = ctrl_reg;
      CCD_IDX_DCC: rd_byte = dcc_reg;
      CCD_IDX_STATUS: rd_byte = status_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus slave next state: zero wait states, write lands in data phase
  always_comb begin
    s1_counts_next = s1_counts_reg;
    phase_next = phase_reg;
    s2_counts_next = s2_counts_reg;
    ctrl_next = ctrl_reg;
    dcc_next = dcc_reg;
    hready_next = 1'b1;
    hrdata_next = hrdata_reg;
    wr_pend_next = addr_ok && i_ahb.hwrite;
    wr_idx_next = a_idx;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        CCD_IDX_S1_COUNTS: s1_counts_next = i_ahb.hwdata[7:0]; // R1 R2
        CCD_IDX_PHASE: phase_next = i_ahb.hwdata[7:0]; // R6
        CCD_IDX_S2_COUNTS: s2_counts_next = i_ahb.hwdata[7:0]; // R3 R4
        // Reserved control bits are kept at zero
        CCD_IDX_CTRL: ctrl_next = {2'h0, i_ahb.hwdata[5:0]};
        CCD_IDX_DCC: dcc_next = {7'h00, i_ahb.hwdata[CCD_BIT_DCC_OFF]};
        default: ;
      endcase
    end
    if (addr_ok && !i_ahb.hwrite) begin
      // Forward a write still in its data phase to avoid a stale read
      // The register itself only updates at the end of that data phase,
      // so a back-to-back read would otherwise see the old byte
      if (wr_pend_reg && wr_idx_reg == a_idx && a_idx != CCD_IDX_STATUS) begin
        hrdata_next = {24'h000000, i_ahb.hwdata[7:0]};
      end else begin
        hrdata_next = {24'h000000, rd_byte};
      end
    end
  end

  // Bus slave registers
  // Registers return to their documented defaults
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_counts_reg <= CCD_RST_BYTE; // R5
      phase_reg <= CCD_RST_BYTE; // R6
      s2_counts_reg <= CCD_RST_BYTE; // R5
      ctrl_reg <= CCD_RST_BYTE;
      dcc_reg <= CCD_RST_BYTE;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b0;
    end else begin
      s1_counts_reg <= s1_counts_next;
      phase_reg <= phase_next;
      s2_counts_reg <= s2_counts_next;
      ctrl_reg <= ctrl_next;
      dcc_reg <= dcc_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= hready_next;
    end
  end

  // Divider next state; phase offsets are stored but not applied
  always_comb begin
    s1_next = s1_reg;
    s2_next = s2_reg;
    rise1 = 1'b0;
    st_next = st_reg;
    // Sync mode selection
    case (st_reg)
      CCD_RUN: begin
        // Normal counting; a sync either holds or forces
        if (i_sync && ctrl_reg[CCD_BIT_NOSYNC]) begin
          st_next = CCD_FORCE; // R9 R10
        end else if (i_sync) begin
          st_next = CCD_HOLD; // R9
        end
      end
      CCD_HOLD: begin
        // Stages held at start levels until sync falls
        if (!i_sync) begin
          st_next = CCD_RUN;
        end else if (ctrl_reg[CCD_BIT_NOSYNC]) begin
          st_next = CCD_FORCE; // R9 R10
        end
      end
      CCD_FORCE: begin
        // Static level shown; stages keep running underneath
        if (!i_sync) begin
          st_next = CCD_RUN;
        end else if (!ctrl_reg[CCD_BIT_NOSYNC]) begin
          st_next = CCD_HOLD; // R9
        end
      end
      default: st_next = CCD_RUN;
    endcase
    if (i_sync && !ctrl_reg[CCD_BIT_NOSYNC]) begin
      // Held at start levels while sync is asserted
      s1_next = stage_start(ctrl_reg[CCD_BIT_START1], s1_counts_reg); // R12
      s2_next = stage_start(ctrl_reg[CCD_BIT_START2], s2_counts_reg); // R11
      if (ctrl_reg[CCD_BIT_BYP2]) begin
        // A bypassed stage two shows the held stage one level
        s2_next.lvl = s1_next.lvl; // R7
        s2_next.cnt = CCD_CNT_ZERO;
      end
    end else begin
      // Stage one counts every input cycle
      if (ctrl_reg[CCD_BIT_BYP1]) begin
        s1_next.lvl = ~s1_reg.lvl; // R8
        s1_next.cnt = CCD_CNT_ZERO;
      end else begin
        s1_next = stage_step(s1_reg, s1_counts_reg); // R1 R2 R5 R15
      end
      rise1 = s1_next.lvl && !s1_reg.lvl;
      // Stage two is clocked by stage one rising edges
      if (ctrl_reg[CCD_BIT_BYP2]) begin
        s2_next.lvl = s1_next.lvl; // R7
        s2_next.cnt = CCD_CNT_ZERO;
      end else if (rise1) begin
        s2_next = stage_step(s2_reg, s2_counts_reg); // R3 R4 R14 R15
      end
    end
    // Static level only while sync is ignored and asserted
    out_next = (st_next == CCD_FORCE) ? ctrl_reg[CCD_BIT_FORCE] : s2_next.lvl; // R10
    dcc_en_next = ~dcc_reg[CCD_BIT_DCC_OFF]; // R13
  end

  // Divider registers
  // Both stages low after reset, so the channel divides by four
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      st_reg <= CCD_RUN;
      out_reg <= 1'b0;
      dcc_en_reg <= 1'b1;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      st_reg <= st_next;
      out_reg <= out_next;
      dcc_en_reg <= dcc_en_next;
    end
  end

  // Elaboration checks: count fields must match the stage counter width, register index must fit the bus address
  localparam int CNT_W = $bits(ccd_stage_t) - 1;
  if (CCD_LOW_MSB - CCD_LOW_LSB + 1 != CNT_W) begin : g_low_w_chk
    $error("low count field width does not match the stage counter");
  end
  if (CCD_HIGH_MSB - CCD_HIGH_LSB + 1 != CNT_W) begin : g_high_w_chk
    $error("high count field width does not match the stage counter");
  end
  if (CCD_IDX_LSB + CCD_IDX_W > 32) begin : g_idx_w_chk
    $error("register index does not fit the bus address");
  end

  // Outputs straight from flops
  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = hready_reg;
  // Slave never stalls or errors, so the response is fixed
  assign o_hresp = CCD_HRESP_OKAY;
  assign o_ch_out = out_reg;
  assign o_duty_correct_en = dcc_en_reg;
endmodule : ccd_divider
`default_nettype wire

// file: pkg/ccd_pkg.sv
/*
  Package for the channel four cascaded clock divider: register indices,
  field positions, reset values, bus codes and carrier types.
  Assumes an AHB-Lite master with 32-bit data and single word transfers.
*/
package ccd_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [9:0] CCD_IDX_S1_COUNTS = 10'h19e;
  localparam logic [9:0] CCD_IDX_PHASE = 10'h19f;
  localparam logic [9:0] CCD_IDX_S2_COUNTS = 10'h1a0;
  localparam logic [9:0] CCD_IDX_CTRL = 10'h1a1;
  localparam logic [9:0] CCD_IDX_DCC = 10'h1a2;
  localparam logic [9:0] CCD_IDX_STATUS = 10'h1a3;
  localparam int CCD_IDX_LSB = 2;
  localparam int CCD_IDX_W = 10;

  // Field positions
  localparam int CCD_LOW_MSB = 7;
  localparam int CCD_LOW_LSB = 4;
  localparam int CCD_HIGH_MSB = 3;
  localparam int CCD_HIGH_LSB = 0;
  localparam int CCD_BIT_BYP2 = 5;
  localparam int CCD_BIT_BYP1 = 4;
  localparam int CCD_BIT_NOSYNC = 3;
  localparam int CCD_BIT_FORCE = 2;
  localparam int CCD_BIT_START2 = 1;
  localparam int CCD_BIT_START1 = 0;
  localparam int CCD_BIT_DCC_OFF = 0;

  // Reset values
  localparam logic [7:0] CCD_RST_BYTE = 8'h00;
  localparam logic [3:0] CCD_CNT_ZERO = 4'h0;

  // Bus codes
  localparam logic [1:0] CCD_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CCD_HTRANS_SEQ = 2'h3;
  localparam logic CCD_HRESP_OKAY = 1'b0;

  // Sync handling states, one-hot
  typedef enum logic [2:0] {
    CCD_RUN = 3'h1,
    CCD_HOLD = 3'h2,
    CCD_FORCE = 3'h4
  } ccd_sync_state_t;

  // AHB-Lite address and data phase signals from the master
  typedef struct packed {
    logic hsel;
    logic hready;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } ccd_ahb_req_t;

  // One divider stage: counter and output level
  typedef struct packed {
    logic [3:0] cnt;
    logic lvl;
  } ccd_stage_t;
endpackage : ccd_pkg

// file: tb/ccd_divider_checker.sv
/* Checker for the channel four divider, bound to its ports.
   Assumes registers change only through the AHB-Lite port. */
`timescale 1ns/10ps
`default_nettype none
module ccd_divider_checker
  import ccd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire ccd_pkg::ccd_ahb_req_t i_ahb,
  input wire logic i_sync,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_ch_out,
  input wire logic o_duty_correct_en
);
  logic tk;
  logic wr_q;
  logic [9:0] idx_q;
  logic [5:0] ctl;
  logic dcc;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  assign tk = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
  // Shadow registers; write data lands one cycle after its address
  always_ff @(posedge i_sys_clk) begin
    wr_q <= !i_sys_rst && tk && i_ahb.hwrite;
    idx_q <= i_ahb.haddr[11:2];
    if (i_sys_rst) ctl <= 6'h00;
    else if (wr_q && idx_q == CCD_IDX_CTRL) ctl <= i_ahb.hwdata[5:0];
    if (i_sys_rst) dcc <= 1'b0;
    else if (wr_q && idx_q == CCD_IDX_DCC) dcc <= i_ahb.hwdata[0];
  end
  chk_resp_okay:
    assert property (o_hresp == CCD_HRESP_OKAY) else $error("bad hresp");
  chk_ready_up:
    assert property (!$past(i_sys_rst) |-> o_hreadyout) else $error("hreadyout low");
  chk_upper_zero:
    assert property (o_hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
  chk_ctrl_read:
    assert property (tk && !i_ahb.hwrite && i_ahb.haddr[11:2] == CCD_IDX_CTRL
      |=> o_hrdata == {26'h0, ctl}) else $error("control readback");
  chk_sync_hold:
    assert property ((i_sync && !ctl[3] && !ctl[5]) [*2] |=> o_ch_out == ctl[1])
      else $error("start level not held");
  chk_force_lvl:
    assert property ((i_sync && ctl[3]) [*2] |=> o_ch_out == ctl[2]) else $error("force level");
  chk_dcc_flag:
    assert property (dcc == $past(dcc) |-> o_duty_correct_en == !dcc) else $error("dcc flag");
  chk_out_moves:
    assert property (disable iff (i_sys_rst || i_sync)
      $changed(o_ch_out) |-> ##[1:600] $changed(o_ch_out)) else $error("output stuck");
endmodule : ccd_divider_checker
bind ccd_divider ccd_divider_checker u_chk (.i_sys_clk, .i_sys_rst, .i_ahb, .i_sync,
  .o_hrdata, .o_hreadyout, .o_hresp, .o_ch_out, .o_duty_correct_en);
`default_nettype wire

// file: tb/tb_top.sv
/* Testbench for the channel four divider: registers, ratios, bypass, sync.
   Assumes the checker file is compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ccd_pkg::*;
  localparam logic [7:0] MASK [6] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h01, 8'h00};
  localparam logic [7:0] SCTL [6] = '{8'h02, 8'h00, 8'h0c, 8'h08, 8'h04, 8'h21};
  localparam logic [5:0] SEXP = 6'h25;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sync = 1'b0;
  ccd_ahb_req_t ahb = '0;
  ccd_ahb_req_t ahb_in;
  logic [31:0] q;
  logic rdy;
  logic ch;
  logic dcc_en;
  int errors = 0;
  int n_compared = 0;
  int h;
  int l;
  // Clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // One slave, so its answer is the bus ready
  always_comb begin
    ahb_in = ahb;
    ahb_in.hready = rdy;
  end
  ccd_divider u_ccd_divider (.i_sys_clk(clk), .i_sys_rst(rst), .i_ahb(ahb_in),
    .i_sync(sync), .o_hrdata(q), .o_hreadyout(rdy), .o_hresp(), .o_ch_out(ch),
    .o_duty_correct_en(dcc_en));
  task summarize;
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Single word transfer; read data taken at the data phase edge
  task bus(input logic w, input logic [9:0] ix, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    ahb.hsel <= 1'b1;
    ahb.htrans <= CCD_HTRANS_NONSEQ;
    ahb.haddr <= {20'h0, ix, 2'h0};
    ahb.hwrite <= w;
    ahb.hsize <= 3'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    ahb.htrans <= 2'h0;
    ahb.hwdata <= {24'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    r = q;
  endtask : bus
  // Third full output period; the second pass skips one, the first may straddle a change
  task meas;
    repeat (2) begin
      do @(negedge clk); while (ch);
      do @(negedge clk); while (!ch);
      for (h = 0; ch; h++) @(negedge clk);
      for (l = 0; !ch; l++) @(negedge clk);
    end
  endtask : meas
  task t_regs;
    logic [9:0] ix;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      ix = (i == 5) ? 10'h1a4 : CCD_IDX_S1_COUNTS + 10'(i);
      bus(1'b0, ix, 8'h00, r);
      chk(r, 32'h0);
      bus(1'b1, ix, 8'hff, r);
      bus(1'b0, ix, 8'h00, r);
      chk(r, {24'h0, MASK[i]});
      chk(dcc_en, i != 4);
      bus(1'b1, ix, 8'h00, r);
    end
  endtask : t_regs
  task t_div;
    logic [31:0] r;
    meas;
    chk(h, 2);
    chk(l, 2);
    bus(1'b1, CCD_IDX_S1_COUNTS, 8'h12, r);
    bus(1'b1, CCD_IDX_S2_COUNTS, 8'h01, r);
    meas;
    chk(h, 10);
    chk(l, 5);
    bus(1'b1, CCD_IDX_CTRL, 8'h10, r);
    meas;
    chk(h, 4);
    chk(l, 2);
    bus(1'b1, CCD_IDX_CTRL, 8'h20, r);
    meas;
    chk(h, 3);
    chk(l, 2);
  endtask : t_div
  task t_sync;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, CCD_IDX_CTRL, SCTL[i], r);
      sync <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(ch, SEXP[i]);
      @(posedge clk);
      sync <= 1'b0;
    end
  endtask : t_sync
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    errors++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_div;
    t_sync;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
